// ===== hdl/tss_pkg.sv
// Package: constants, codes and carriers of the trigger source sequencer
package tss_pkg;

  // ----------------------------------------------------------------
  // Clock and hold-off timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_STEP_NS = 100;
  localparam int HOLD_STEP_CYC = HOLD_STEP_NS / CLK_PERIOD_NS;
  localparam longint HOLDOFF_MAX_S = 10;
  localparam longint HOLDOFF_MAX_STEPS = HOLDOFF_MAX_S * 64'd1000000000 / HOLD_STEP_NS;
  localparam int HOLD_W = 27;
  localparam int DIV_W = 4;

  // ----------------------------------------------------------------
  // Widths, counts and reset values
  // ----------------------------------------------------------------
  localparam int NUM_CH = 16;
  localparam int NUM_BITS = 16;
  localparam int PORT_BITS = 8;
  localparam logic [7:0] COUNT_RESET = 8'h01;
  localparam logic [7:0] COUNT_MIN = 8'h01;
  localparam logic [6:0] POS_RESET = 7'h32;
  localparam logic [6:0] POS_MAX = 7'h64;
  localparam logic [22:0] POS_DIV = 23'h000064;
  localparam int IV_LAST = 30;

  // Pattern codes per channel or bit
  localparam logic [1:0] CODE_X = 2'h0;
  localparam logic [1:0] CODE_H = 2'h1;
  localparam logic [1:0] CODE_L = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SRC_EXT, SRC_MAINS, SRC_TIMER, SRC_LOGIC} tss_src_e;
  typedef enum logic {SQ_WAIT_A, SQ_COUNT_B} tss_seq_e;

  typedef struct packed {
    tss_src_e src;
    logic slope_fall;
    logic logic_port_b;
    logic [2:0] logic_bit;
    logic enhanced;
    logic [HOLD_W-1:0] holdoff_steps;
    logic [4:0] timer_iv;
    logic [31:0] ref_min;
  } tss_cfg_s;

  typedef struct packed {
    logic [NUM_CH-1:0][1:0] ch_code;
    logic [1:0] port_en;
    logic [NUM_BITS-1:0][1:0] bit_code;
    logic leave;
  } tss_cond_s;

  typedef struct packed {
    logic [NUM_CH-1:0] ch_above;
    logic [PORT_BITS-1:0] logic_a;
    logic [PORT_BITS-1:0] logic_b;
    logic outside_trigger_pin;
    logic mains;
  } tss_in_s;

  // Timer interval table in minutes
  function automatic logic [10:0] tss_iv_min(input logic [4:0] idx);
    logic [10:0] m;
    m = 11'h001;
    case (idx)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09: begin
        m = 11'({6'h00, idx} + 11'h001);
      end
      5'h0A: m = 11'h00F;
      5'h0B: m = 11'h014;
      5'h0C: m = 11'h019;
      5'h0D: m = 11'h01E;
      5'h0E: m = 11'h028;
      5'h0F: m = 11'h02D;
      5'h10: m = 11'h032;
      5'h1D: m = 11'h438;
      5'h1E: m = 11'h5A0;
      default: begin
        if (idx > 5'h10 && idx < 5'h1D) begin
          m = 11'(11'h03C * {6'h00, idx - 5'h10});
        end
      end
    endcase
    return m;
  endfunction : tss_iv_min

endpackage : tss_pkg

// ===== hdl/tss_top.sv
// Trigger source sequencer: simple sources, A then B(N) sequence, hold-off, arming
`timescale 1ns/1ps
module tss_top
  import tss_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire tss_in_s i_in,
  input wire tss_cfg_s i_cfg,
  input wire tss_cond_s [1:0] i_cond,
  input wire logic i_count_wr,
  input wire logic [7:0] i_count_val,
  input wire logic i_count_rst,
  input wire logic i_pos_wr,
  input wire logic [6:0] i_pos_pct,
  input wire logic [15:0] i_record_len,
  input wire logic i_start,
  input wire logic [15:0] i_acq_total,
  input wire logic i_stop,
  input wire logic i_acq_busy,
  input wire logic [31:0] i_now_min,
  output logic o_trig,
  output logic o_armed,
  output logic o_holdoff_active,
  output logic o_wait_b,
  output logic [7:0] o_count_cfg,
  output logic [6:0] o_pos_pct,
  output logic [15:0] o_pre_count
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    tss_in_s in_now, in_prev;
    logic [1:0] m_prev;
    tss_seq_e seq;
    logic [7:0] bcnt, count;
    tss_cond_s [1:0] cond_copy;
    logic [7:0] count_copy;
    logic enh_copy;
    logic [31:0] timer_next, timer_ref;
    logic [4:0] timer_iv;
    logic [HOLD_W-1:0] hold;
    logic [DIV_W-1:0] div;
    logic hold_on, armed, acq_inf;
    logic [15:0] acq_left;
    logic [6:0] pos;
    logic [15:0] pre_cnt;
    logic trig;
  } tss_state_s;
  tss_state_s state_ff;
  tss_state_s nxt_state;

  // ----------------------------------------------------------------
  // Pattern matching
  // ----------------------------------------------------------------
  logic [1:0][NUM_CH-1:0] ch_ok, ch_x;
  logic [1:0][NUM_BITS-1:0] bit_ok, bit_x;
  logic [NUM_BITS-1:0] port_bits;
  logic [1:0] match;
  logic b_free;
  assign port_bits = {state_ff.in_now.logic_b, state_ff.in_now.logic_a};
  for (genvar c = 0; c < 2; c++) begin : g_cond
    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
      assign ch_ok[c][k] = (i_cond[c].ch_code[k] == CODE_H) ? state_ff.in_now.ch_above[k] :
                           (i_cond[c].ch_code[k] == CODE_L) ? !state_ff.in_now.ch_above[k] :
                           1'b1;
      assign ch_x[c][k] = (i_cond[c].ch_code[k] == CODE_X);
    end
    for (genvar k = 0; k < NUM_BITS; k++) begin : g_bit
      assign bit_ok[c][k] = (i_cond[c].bit_code[k] == CODE_H) ? port_bits[k] :
                            (i_cond[c].bit_code[k] == CODE_L) ? !port_bits[k] :
                            1'b1;
      assign bit_x[c][k] = (i_cond[c].bit_code[k] == CODE_X);
    end
    assign match[c] = (&ch_ok[c]) &
                      (!i_cond[c].port_en[0] | (&bit_ok[c][PORT_BITS-1:0])) &
                      (!i_cond[c].port_en[1] | (&bit_ok[c][NUM_BITS-1:PORT_BITS]));
  end
  assign b_free = (&ch_x[1]) &
                  (!i_cond[1].port_en[0] | (&bit_x[1][PORT_BITS-1:0])) &
                  (!i_cond[1].port_en[1] | (&bit_x[1][NUM_BITS-1:PORT_BITS]));
  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [1:0] cond_evt;
  logic ext_evt, mains_evt, logic_evt, timer_hit;
  logic lbit_now, lbit_prev, hold_act, cfg_changed;
  logic [10:0] iv_min;
  assign cond_evt[0] = i_cond[0].leave ? (!match[0] & state_ff.m_prev[0]) :
                                         (match[0] & !state_ff.m_prev[0]);
  assign cond_evt[1] = i_cond[1].leave ? (!match[1] & state_ff.m_prev[1]) :
                                         (match[1] & !state_ff.m_prev[1]);
  assign ext_evt = i_cfg.slope_fall ?
                   (state_ff.in_prev.outside_trigger_pin & !state_ff.in_now.outside_trigger_pin) :
                   (!state_ff.in_prev.outside_trigger_pin & state_ff.in_now.outside_trigger_pin);
  assign mains_evt = !state_ff.in_prev.mains & state_ff.in_now.mains;
  assign lbit_now = i_cfg.logic_port_b ? state_ff.in_now.logic_b[i_cfg.logic_bit] :
                                         state_ff.in_now.logic_a[i_cfg.logic_bit];
  assign lbit_prev = i_cfg.logic_port_b ? state_ff.in_prev.logic_b[i_cfg.logic_bit] :
                                          state_ff.in_prev.logic_a[i_cfg.logic_bit];
  assign logic_evt = i_cfg.slope_fall ? (lbit_prev & !lbit_now) : (!lbit_prev & lbit_now);
  assign iv_min = tss_iv_min(i_cfg.timer_iv);
  assign timer_hit = (i_now_min == state_ff.timer_next);
  assign hold_act = (state_ff.hold != '0);
  assign cfg_changed = (i_cond != state_ff.cond_copy) || (state_ff.count != state_ff.count_copy) ||
                       (i_cfg.enhanced != state_ff.enh_copy);
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic fire;
  logic [22:0] pos_prod;
  always_comb begin
    nxt_state = state_ff;
    fire = 1'b0;
    pos_prod = 23'(i_record_len) * 23'(state_ff.pos);
    nxt_state.in_now = i_in;
    nxt_state.in_prev = state_ff.in_now;
    nxt_state.m_prev = match;
    nxt_state.trig = 1'b0;
    nxt_state.cond_copy = i_cond;
    nxt_state.count_copy = state_ff.count;
    nxt_state.enh_copy = i_cfg.enhanced;
    if (i_count_rst) begin
      nxt_state.count = COUNT_RESET;
    end else if (i_count_wr) begin
      nxt_state.count = (i_count_val < COUNT_MIN) ? COUNT_MIN : i_count_val;
    end
    if (i_pos_wr) begin
      nxt_state.pos = (i_pos_pct > POS_MAX) ? POS_MAX : i_pos_pct;
    end
    nxt_state.pre_cnt = 16'(pos_prod / POS_DIV);
    if ((i_cfg.ref_min != state_ff.timer_ref) || (i_cfg.timer_iv != state_ff.timer_iv)) begin
      nxt_state.timer_ref = i_cfg.ref_min;
      nxt_state.timer_iv = i_cfg.timer_iv;
      nxt_state.timer_next = i_cfg.ref_min;
    end else if (timer_hit || (i_now_min > state_ff.timer_next)) begin
      nxt_state.timer_next = state_ff.timer_next + 32'(iv_min);
    end
    if (state_ff.div == DIV_W'(HOLD_STEP_CYC - 1)) begin
      nxt_state.div = '0;
      if (hold_act) begin
        nxt_state.hold = state_ff.hold - HOLD_W'(1);
      end
    end else begin
      nxt_state.div = state_ff.div + DIV_W'(1);
    end
    if (!i_cfg.enhanced) begin
      nxt_state.seq = SQ_WAIT_A;
      nxt_state.bcnt = '0;
      case (i_cfg.src)
        SRC_EXT: fire = ext_evt && !hold_act;
        SRC_MAINS: fire = mains_evt && !hold_act;
        SRC_TIMER: fire = timer_hit && !i_acq_busy && !hold_act;
        SRC_LOGIC: fire = logic_evt && !hold_act;
        default: fire = 1'b0;
      endcase
    end else if (cfg_changed) begin
      nxt_state.seq = SQ_WAIT_A;
      nxt_state.bcnt = '0;
    end else begin
      case (state_ff.seq)
        SQ_WAIT_A: begin
          if (cond_evt[0]) begin
            if (b_free) begin
              fire = !hold_act;
            end else begin
              nxt_state.seq = SQ_COUNT_B;
              nxt_state.bcnt = '0;
            end
          end
        end
        SQ_COUNT_B: begin
          if (cond_evt[1] && !hold_act) begin
            if ((9'(state_ff.bcnt) + 9'h001) >= 9'(state_ff.count)) begin
              fire = 1'b1;
              nxt_state.seq = SQ_WAIT_A;
              nxt_state.bcnt = '0;
            end else begin
              nxt_state.bcnt = state_ff.bcnt + 8'h01;
            end
          end
        end
        default: nxt_state.seq = SQ_WAIT_A;
      endcase
    end
    if (i_stop) begin
      nxt_state.armed = 1'b0;
    end else if (i_start) begin
      nxt_state.armed = 1'b1;
      nxt_state.acq_inf = (i_acq_total == 16'h0000);
      nxt_state.acq_left = i_acq_total;
    end else if (fire && state_ff.armed) begin
      nxt_state.trig = 1'b1;
      nxt_state.hold = (64'(i_cfg.holdoff_steps) > HOLDOFF_MAX_STEPS) ?
                       HOLD_W'(HOLDOFF_MAX_STEPS) : i_cfg.holdoff_steps;
      nxt_state.div = '0;
      if (!state_ff.acq_inf) begin
        nxt_state.acq_left = state_ff.acq_left - 16'h0001;
        if (state_ff.acq_left <= 16'h0001) begin
          nxt_state.armed = 1'b0;
        end
      end
    end
    nxt_state.hold_on = (nxt_state.hold != '0);
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      state_ff <= '0;
      state_ff.count <= COUNT_RESET;
      state_ff.count_copy <= COUNT_RESET;
      state_ff.pos <= POS_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end
  assign o_trig = state_ff.trig;
  assign o_armed = state_ff.armed;
  assign o_holdoff_active = state_ff.hold_on;
  assign o_wait_b = (state_ff.seq == SQ_COUNT_B);
  assign o_count_cfg = state_ff.count;
  assign o_pos_pct = state_ff.pos;
  assign o_pre_count = state_ff.pre_cnt;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic simple_go;
  assign simple_go = !i_cfg.enhanced && state_ff.armed && !i_stop && !i_start && !hold_act;
  sequence s_ext_edge;
    simple_go && (i_cfg.src == SRC_EXT) && ext_evt;
  endsequence
  sequence s_b_last;
    i_cfg.enhanced && !cfg_changed && (state_ff.seq == SQ_COUNT_B) && cond_evt[1] && !hold_act &&
    ((9'(state_ff.bcnt) + 9'h001) >= 9'(state_ff.count)) && state_ff.armed && !i_stop && !i_start;
  endsequence
  property p_ext_fire;
    @(posedge i_clk_sys) disable iff (!i_rstn) s_ext_edge |=> o_trig;
  endproperty
  a_ext_fire: assert property (p_ext_fire) else $error("external edge did not trigger");
  property p_ext_slope;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      o_trig && $past(!i_cfg.enhanced && i_cfg.src == SRC_EXT && !i_cfg.slope_fall) |->
      $past(!state_ff.in_prev.outside_trigger_pin && state_ff.in_now.outside_trigger_pin);
  endproperty
  a_ext_slope: assert property (p_ext_slope) else $error("rising trigger without rise");
  property p_mains_rise;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      o_trig && $past(!i_cfg.enhanced && i_cfg.src == SRC_MAINS) |-> $past(mains_evt);
  endproperty
  a_mains_rise: assert property (p_mains_rise) else $error("mains trigger without rise");
  property p_timer_discard;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      !i_cfg.enhanced && i_cfg.src == SRC_TIMER && i_acq_busy |=> !o_trig;
  endproperty
  a_timer_discard: assert property (p_timer_discard) else $error("timer fired while busy");
  property p_count_reset;
    @(posedge i_clk_sys) disable iff (!i_rstn) i_count_rst |=> o_count_cfg == 8'h01;
  endproperty
  a_count_reset: assert property (p_count_reset) else $error("count reset not one");
  property p_count_range;
    @(posedge i_clk_sys) disable iff (!i_rstn) o_count_cfg != 8'h00;
  endproperty
  a_count_range: assert property (p_count_range) else $error("count is zero");
  property p_seq_fire;
    @(posedge i_clk_sys) disable iff (!i_rstn) s_b_last |=> o_trig && !o_wait_b;
  endproperty
  a_seq_fire: assert property (p_seq_fire) else $error("Nth B did not fire");
  property p_holdoff;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      o_trig && $past(i_cfg.holdoff_steps) != '0 |-> o_holdoff_active ##1 !o_trig;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("hold-off not applied");
  property p_finite_stop;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      o_trig && $past(!state_ff.acq_inf && state_ff.acq_left == 16'h0001 && !i_start) |-> !o_armed;
  endproperty
  a_finite_stop: assert property (p_finite_stop) else $error("last acquisition kept armed");
  property p_pulse_armed;
    @(posedge i_clk_sys) disable iff (!i_rstn) o_trig |-> $past(state_ff.armed);
  endproperty
  a_pulse_armed: assert property (p_pulse_armed) else $error("trigger while disarmed");
endmodule : tss_top

// ===== verif/tss_acq_model.sv
// Acquisition control model: busy after each trigger, or while held
`timescale 1ns/1ps
module tss_acq_model #(
  parameter int BUSY_CYC = 3
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_trig,
  input wire logic i_hold,
  output logic o_acq_busy
);
  // --------------------
  // Busy window
  // --------------------
  int cnt;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cnt <= 0;
    end else if (i_trig) begin
      cnt <= BUSY_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // Hold stands for a long pre-trigger period
  assign o_acq_busy = i_hold | (cnt > 0);
endmodule : tss_acq_model

// ===== verif/test_tss_top.sv
// Self-checking bench of the trigger source sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module test_tss_top
  import tss_pkg::*;
;
  // --------------------
  // Stimulus and wiring
  // --------------------
  logic clk, rstn, cwr, crst, pwr, start, stop, hold, trig, armed, hoa, waitb, busy;
  logic [7:0] cval, count_cfg;
  logic [6:0] pos, pos_o;
  logic [15:0] rec_len, total, pre;
  logic [31:0] now;
  tss_in_s din;
  tss_cfg_s cfg;
  tss_cond_s [1:0] cond;
  int failures = 0;
  int n_tests = 0;
  logic [4:0] iv_idx [7] = '{5'h00, 5'h09, 5'h0A, 5'h10, 5'h11, 5'h1D, 5'h1E};
  logic [31:0] iv_min [7] = '{32'h1, 32'hA, 32'hF, 32'h32, 32'h3C, 32'h438, 32'h5A0};

  tss_top u_tss_top (
    .i_clk_sys(clk), .i_rstn(rstn), .i_in(din), .i_cfg(cfg), .i_cond(cond),
    .i_count_wr(cwr), .i_count_val(cval), .i_count_rst(crst), .i_pos_wr(pwr),
    .i_pos_pct(pos), .i_record_len(rec_len), .i_start(start), .i_acq_total(total),
    .i_stop(stop), .i_acq_busy(busy), .i_now_min(now), .o_trig(trig), .o_armed(armed),
    .o_holdoff_active(hoa), .o_wait_b(waitb), .o_count_cfg(count_cfg),
    .o_pos_pct(pos_o), .o_pre_count(pre));

  tss_acq_model #(.BUSY_CYC(3)) u_tss_acq_model (
    .i_clk_sys(clk), .i_rstn(rstn), .i_trig(trig), .i_hold(hold), .o_acq_busy(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end

  // --------------------
  // Access tasks
  // --------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // Counts trigger cycles over a window
  task automatic see(input logic e, input string nm);
    logic [3:0] n;
    n = 4'h0;
    repeat (6) begin
      step(1);
      if (trig === 1'b1) n = n + 4'h1;
    end
    `CHK(nm, {3'h0, e}, n)
  endtask : see

  task automatic hit(input tss_src_e s, input logic f, input logic v, input logic e,
                     input string nm);
    cfg.src = s;
    cfg.slope_fall = f;
    step(2);
    case (s)
      SRC_EXT: din.outside_trigger_pin = v;
      SRC_MAINS: din.mains = v;
      default: din.logic_b[2] = v;
    endcase
    see(e, nm);
  endtask : hit

  task automatic wcount(input logic [7:0] v, input logic r);
    cval = v;
    cwr = 1'b1;
    crst = r;
    step(1);
    cwr = 1'b0;
    crst = 1'b0;
    step(1);
  endtask : wcount

  task automatic wpos(input logic [6:0] v);
    pos = v;
    pwr = 1'b1;
    step(1);
    pwr = 1'b0;
    step(1);
  endtask : wpos

  task automatic arm(input logic s, input logic [15:0] t);
    start = s;
    stop = ~s;
    total = t;
    step(1);
    start = 1'b0;
    stop = 1'b0;
    step(1);
  endtask : arm

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // --------------------
  // Tests
  // --------------------
  initial begin
    {rstn, cwr, crst, pwr, start, stop, hold} = '0;
    {cval, pos, rec_len, total, now} = '0;
    din = '0;
    cfg = '0;
    cond = '0;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    step(2);
    `CHK("count_rst", 8'h01, count_cfg)
    `CHK("pos_rst", 7'h32, pos_o)
    wcount(8'hFF, 1'b0);
    `CHK("count_max", 8'hFF, count_cfg)
    wcount(8'h00, 1'b0);
    `CHK("count_zero", 8'h01, count_cfg)
    wcount(8'h05, 1'b1);
    `CHK("count_reset", 8'h01, count_cfg)
    rec_len = 16'h00C8;
    wpos(7'h19);
    `CHK("pre_25", 16'h0032, pre)
    wpos(7'h78);
    `CHK("pos_clamp", 7'h64, pos_o)
    `CHK("pre_100", 16'h00C8, pre)
    wpos(7'h00);
    `CHK("pre_0", 16'h0000, pre)
    done("config");
    arm(1'b1, 16'h0000);
    hit(SRC_EXT, 1'b0, 1'b1, 1'b1, "ext_rise");
    hit(SRC_EXT, 1'b0, 1'b0, 1'b0, "ext_rise_fall");
    hit(SRC_EXT, 1'b1, 1'b1, 1'b0, "ext_fall_rise");
    hit(SRC_EXT, 1'b1, 1'b0, 1'b1, "ext_fall");
    hit(SRC_MAINS, 1'b1, 1'b1, 1'b1, "mains_rise");
    hit(SRC_MAINS, 1'b1, 1'b0, 1'b0, "mains_fall");
    cfg.logic_port_b = 1'b1;
    cfg.logic_bit = 3'h2;
    hit(SRC_LOGIC, 1'b0, 1'b1, 1'b1, "logic_rise");
    din.logic_b[3] = 1'b1;
    see(1'b0, "logic_other_bit");
    hit(SRC_LOGIC, 1'b1, 1'b0, 1'b1, "logic_fall");
    done("simple");
    cfg.holdoff_steps = 27'h2;
    hit(SRC_EXT, 1'b0, 1'b1, 1'b1, "hold_first");
    `CHK("hold_active", 1'b1, hoa)
    hit(SRC_EXT, 1'b0, 1'b0, 1'b0, "hold_fall");
    hit(SRC_EXT, 1'b0, 1'b1, 1'b0, "hold_block");
    step(10);
    hit(SRC_EXT, 1'b0, 1'b0, 1'b0, "hold_fall2");
    hit(SRC_EXT, 1'b0, 1'b1, 1'b1, "hold_over");
    cfg.holdoff_steps = 27'h0;
    din.outside_trigger_pin = 1'b0;
    step(30);
    done("holdoff");
    cfg.src = SRC_TIMER;
    for (int k = 0; k < 7; k++) begin
      cfg.timer_iv = iv_idx[k];
      cfg.ref_min = 32'h3E8 + 32'(k) * 32'hFA0;
      now = cfg.ref_min - 32'h1;
      step(3);
      now = cfg.ref_min;
      see(1'b1, "timer_ref");
      now = cfg.ref_min + iv_min[k];
      see(1'b1, "timer_iv");
    end
    cfg.timer_iv = 5'h01;
    cfg.ref_min = 32'h32;
    now = 32'h67;
    step(40);
    now = 32'h68;
    see(1'b1, "timer_past");
    hold = 1'b1;
    now = 32'h6A;
    see(1'b0, "timer_busy");
    hold = 1'b0;
    now = 32'h6C;
    see(1'b1, "timer_after");
    done("timer");
    arm(1'b0, 16'h0000);
    `CHK("armed_stop", 1'b0, armed)
    hit(SRC_EXT, 1'b0, 1'b1, 1'b0, "disarmed");
    hit(SRC_EXT, 1'b0, 1'b0, 1'b0, "disarmed_fall");
    arm(1'b1, 16'h0002);
    hit(SRC_EXT, 1'b0, 1'b1, 1'b1, "finite_1");
    hit(SRC_EXT, 1'b0, 1'b0, 1'b0, "finite_fall");
    hit(SRC_EXT, 1'b0, 1'b1, 1'b1, "finite_2");
    `CHK("armed_end", 1'b0, armed)
    hit(SRC_EXT, 1'b0, 1'b0, 1'b0, "finite_fall2");
    hit(SRC_EXT, 1'b0, 1'b1, 1'b0, "finite_over");
    din.outside_trigger_pin = 1'b0;
    arm(1'b1, 16'h0000);
    done("count");
    cfg.enhanced = 1'b1;
    cond[0].ch_code[0] = CODE_H;
    cond[1].ch_code[1] = CODE_H;
    wcount(8'h03, 1'b0);
    step(3);
    din.ch_above[0] = 1'b1;
    step(4);
    `CHK("wait_b", 1'b1, waitb)
    for (int i = 1; i <= 3; i++) begin
      din.ch_above[1] = 1'b1;
      see(i == 3, "b_count");
      din.ch_above[1] = 1'b0;
      step(2);
    end
    `CHK("wait_a_again", 1'b0, waitb)
    din.ch_above[1] = 1'b1;
    see(1'b0, "b_without_a");
    din.ch_above[1] = 1'b0;
    // leave mode, B all don't care
    cond = '0;
    cond[0].ch_code[2] = CODE_L;
    cond[0].leave = 1'b1;
    din.ch_above[0] = 1'b0;
    step(3);
    din.ch_above[2] = 1'b1;
    see(1'b1, "leave_single");
    cond = '0;
    cond[0].port_en = 2'b01;
    cond[0].bit_code[0] = CODE_H;
    cond[0].bit_code[9] = CODE_L;
    din.ch_above[2] = 1'b0;
    din.logic_b[1] = 1'b1;
    step(3);
    din.logic_a[0] = 1'b1;
    see(1'b1, "port_b_off");
    din.logic_a[0] = 1'b0;
    step(2);
    cond[0].port_en = 2'b11;
    step(3);
    din.logic_a[0] = 1'b1;
    see(1'b0, "port_b_mismatch");
    din.logic_b[1] = 1'b0;
    see(1'b1, "port_b_match");
    done("enhanced");
    final_report();
  end
endmodule : test_tss_top
